//--- src/adcsq_regs.svh
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH

// Register indices, byte address is four times the index
`define ADCSQ_IDX_IRQ_CTRL 8'hc0
`define ADCSQ_IDX_CTRL 8'hd8
`define ADCSQ_IDX_RESULT 8'hd9
`define ADCSQ_IDX_REFPROG 8'hda
`define ADCSQ_IDX_DIGPORT 8'hdb
`define ADCSQ_IDX_CONFIG 8'hdc

// Control, interrupt and config register fields
`define ADCSQ_CTRL_MUX_LSB 0
`define ADCSQ_CTRL_MUX_MSB 2
`define ADCSQ_CTRL_MODE_BIT 3
`define ADCSQ_CTRL_BUSY_BIT 4
`define ADCSQ_IRQ_DONE_BIT 0
`define ADCSQ_CFG_LEGACY_BIT 0

// Reset values
`define ADCSQ_CTRL_RST 8'h00
`define ADCSQ_RESULT_RST 8'h00
`define ADCSQ_REFPROG_RST 8'h00
`define ADCSQ_CONFIG_RST 8'h00

// Timing in oscillator periods and machine cycles
`define ADCSQ_OSC_PER_MC 4'd12
`define ADCSQ_CONV_MC_LOWPWR 4'd13
`define ADCSQ_CONV_MC_LEGACY 4'd15
`define ADCSQ_DECISIONS 4'd8
`define ADCSQ_TAIL_MC 4'd3

`endif

//--- src/adcsq_pkg.sv
package adcsq_pkg;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_DECIDE = 2'b11,
      ST_FINISH = 2'b10
   } adcsq_state_t;

   // Drive towards the analog core
   typedef struct packed {
      logic [2:0] channel_sel;
      logic sample_en;
      logic [7:0] sar_trial;
      logic [3:0] lower_ref_code;
      logic [3:0] upper_ref_code;
      logic lower_ref_external;
      logic upper_ref_external;
   } adcsq_analog_t;

   // Answers from the comparator
   typedef struct packed {
      logic cmp_above_trial;
      logic above_upper_ref;
      logic below_lower_ref;
   } adcsq_compare_t;

endpackage

//--- src/adcsq_ctrl.sv
`include "adcsq_regs.svh"

// Operation
// - Channel select code routes that analog input.
// - Conversion lasts 13 or 15 machine cycles.
// - Mode bit zero gives single conversion.
// - Continuous mode restarts until mode cleared.
// - Busy reads one during conversion.
// - Busy flag ignores software writes.
// - Completion sets the done interrupt flag.
// - Result held until next conversion overwrites.
// - Result register freely readable and writable.
// - Any reference register write starts conversion.
// - Zero nibble selects the external reference.
// - Out-of-range input gives ff or 00.
// - Analog pins readable as digital port, reads zero in legacy mode.
// - Start write aborts, restarts next cycle.
// - Result last cycle, busy and flag earlier.
// - Continuous restart in the following cycle.
// - Machine cycle is twelve clock periods.
module adcsq_ctrl (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog core
   output adcsq_pkg::adcsq_analog_t analog_ctrl,
   input wire adcsq_pkg::adcsq_compare_t analog_cmp,
   input wire logic [7:0] analog_digital_input_port,
   // Status towards the interrupt controller
   output logic conversion_done_irq_flag,
   output logic conversion_busy_flag
);

   logic [7:0] ctrl_reg, ctrl_next;
   logic [7:0] result_reg, result_next;
   logic [7:0] refprog_reg, refprog_next;
   logic legacy_reg, legacy_next;
   logic irq_reg, irq_next;
   logic busy_reg, busy_next;
   logic start_pend_reg, start_pend_next;
   logic [3:0] presc_reg, presc_next;
   logic [3:0] mc_idx_reg, mc_idx_next;
   logic [7:0] trial_reg, trial_next;
   logic [7:0] mask_reg, mask_next;
   logic [7:0] final_reg, final_next;
   logic sample_reg, sample_next;
   adcsq_pkg::adcsq_state_t state_reg, state_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic lower_ext_reg, lower_ext_next;
   logic upper_ext_reg, upper_ext_next;

   logic mc_tick;
   logic apb_access;
   logic apb_commit;
   logic wr_commit;
   logic [9:0] word_idx;
   logic [7:0] idx8;
   logic hit;
   logic [7:0] rd_byte;
   logic [3:0] conv_len;
   logic [3:0] sample_len;
   logic [7:0] resolved;

   // Machine cycle tick
   // twelve clock periods
   assign mc_tick = (presc_reg == (`ADCSQ_OSC_PER_MC - 4'd1));

   assign conv_len = legacy_reg ? `ADCSQ_CONV_MC_LEGACY : `ADCSQ_CONV_MC_LOWPWR;
   assign sample_len = conv_len - `ADCSQ_DECISIONS - `ADCSQ_TAIL_MC;

   // APB decode
   assign apb_access = psel & penable;
   assign apb_commit = apb_access & pready_reg;
   assign wr_commit = apb_commit & pwrite & ~pslverr_reg;
   assign word_idx = paddr[11:2];
   assign idx8 = word_idx[7:0];
   assign hit = (paddr[1:0] == 2'b00) && (word_idx[9:8] == 2'b00) &&
                ((idx8 == `ADCSQ_IDX_IRQ_CTRL) || (idx8 == `ADCSQ_IDX_CTRL) ||
                 (idx8 == `ADCSQ_IDX_RESULT) || (idx8 == `ADCSQ_IDX_REFPROG) ||
                 (idx8 == `ADCSQ_IDX_DIGPORT) || (idx8 == `ADCSQ_IDX_CONFIG));

   // Read mux
   always_comb begin
      rd_byte = 8'h00;
      unique case (idx8)
         `ADCSQ_IDX_IRQ_CTRL: rd_byte = {7'h00, irq_reg};
         `ADCSQ_IDX_CTRL: rd_byte = {3'h0, busy_reg, ctrl_reg[3:0]};
         `ADCSQ_IDX_RESULT: rd_byte = result_reg;
         `ADCSQ_IDX_REFPROG: rd_byte = refprog_reg;
         `ADCSQ_IDX_DIGPORT: rd_byte = legacy_reg ? 8'h00 : analog_digital_input_port;
         `ADCSQ_IDX_CONFIG: rd_byte = {7'h00, legacy_reg};
         default: rd_byte = 8'h00;
      endcase
   end

   // APB answer one cycle into the access phase
   always_comb begin
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      prdata_next = prdata_reg;
      if (apb_access && !pready_reg) begin
         pready_next = 1'b1;
         pslverr_next = ~hit;
         prdata_next = (hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   // SAR decision with the present comparator answer
   always_comb begin
      resolved = trial_reg;
      // keep or drop the trial bit
      if (!analog_cmp.cmp_above_trial) begin
         resolved = trial_reg & ~mask_reg;
      end
   end

   // Register and converter next values
   always_comb begin
      ctrl_next = ctrl_reg;
      result_next = result_reg;
      refprog_next = refprog_reg;
      legacy_next = legacy_reg;
      irq_next = irq_reg;
      busy_next = busy_reg;
      start_pend_next = start_pend_reg;
      presc_next = mc_tick ? 4'd0 : presc_reg + 4'd1;
      mc_idx_next = mc_idx_reg;
      trial_next = trial_reg;
      mask_next = mask_reg;
      final_next = final_reg;
      sample_next = sample_reg;
      state_next = state_reg;

      // Software writes
      if (wr_commit) begin
         unique case (idx8)
            `ADCSQ_IDX_IRQ_CTRL: irq_next = pwdata[`ADCSQ_IRQ_DONE_BIT];
            `ADCSQ_IDX_CTRL: ctrl_next = {4'h0, pwdata[3:0]};
            `ADCSQ_IDX_RESULT: result_next = pwdata[7:0];
            `ADCSQ_IDX_REFPROG: begin
               refprog_next = pwdata[7:0];
               start_pend_next = 1'b1;
            end
            `ADCSQ_IDX_CONFIG: legacy_next = pwdata[`ADCSQ_CFG_LEGACY_BIT];
            default: ;
         endcase
      end

      if (mc_tick) begin
         if (start_pend_reg) begin
            state_next = adcsq_pkg::ST_SAMPLE;
            mc_idx_next = 4'd0;
            busy_next = 1'b1;
            sample_next = 1'b1;
            trial_next = 8'h00;
            mask_next = 8'h00;
            start_pend_next = wr_commit && (idx8 == `ADCSQ_IDX_REFPROG);
         end else begin
            unique case (state_reg)
               adcsq_pkg::ST_IDLE: ;
               adcsq_pkg::ST_SAMPLE: begin
                  mc_idx_next = mc_idx_reg + 4'd1;
                  if (mc_idx_reg >= sample_len - 4'd1) begin
                     state_next = adcsq_pkg::ST_DECIDE;
                     sample_next = 1'b0;
                     trial_next = 8'h80;
                     mask_next = 8'h80;
                  end
               end
               adcsq_pkg::ST_DECIDE: begin
                  mc_idx_next = mc_idx_reg + 4'd1;
                  if (mask_reg == 8'h01) begin
                     state_next = adcsq_pkg::ST_FINISH;
                     trial_next = resolved;
                     if (analog_cmp.above_upper_ref) begin
                        final_next = 8'hff;
                     end else if (analog_cmp.below_lower_ref) begin
                        final_next = 8'h00;
                     end else begin
                        final_next = resolved;
                     end
                     irq_next = 1'b1;
                  end else begin
                     mask_next = {1'b0, mask_reg[7:1]};
                     trial_next = resolved | {1'b0, mask_reg[7:1]};
                  end
               end
               adcsq_pkg::ST_FINISH: begin
                  mc_idx_next = mc_idx_reg + 4'd1;
                  // busy clears before the last cycle
                  if (mc_idx_reg >= conv_len - 4'd3) begin
                     busy_next = 1'b0;
                  end
                  // result written in the last cycle
                  if (mc_idx_reg == conv_len - 4'd2) begin
                     result_next = final_reg;
                  end
                  if (mc_idx_reg >= conv_len - 4'd1) begin
                     if (ctrl_reg[`ADCSQ_CTRL_MODE_BIT]) begin
                        state_next = adcsq_pkg::ST_SAMPLE;
                        mc_idx_next = 4'd0;
                        busy_next = 1'b1;
                        sample_next = 1'b1;
                        trial_next = 8'h00;
                        mask_next = 8'h00;
                     end else begin
                        state_next = adcsq_pkg::ST_IDLE;
                        mc_idx_next = 4'd0;
                     end
                  end
               end
               default: state_next = adcsq_pkg::ST_IDLE;
            endcase
         end
      end

      lower_ext_next = (refprog_next[3:0] == 4'h0);
      upper_ext_next = (refprog_next[7:4] == 4'h0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `ADCSQ_CTRL_RST;
         result_reg <= `ADCSQ_RESULT_RST;
         refprog_reg <= `ADCSQ_REFPROG_RST;
         legacy_reg <= 1'b0;
         irq_reg <= 1'b0;
         busy_reg <= 1'b0;
         start_pend_reg <= 1'b0;
         presc_reg <= 4'd0;
         mc_idx_reg <= 4'd0;
         trial_reg <= 8'h00;
         mask_reg <= 8'h00;
         final_reg <= 8'h00;
         sample_reg <= 1'b0;
         state_reg <= adcsq_pkg::ST_IDLE;
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         lower_ext_reg <= 1'b1;
         upper_ext_reg <= 1'b1;
      end else begin
         ctrl_reg <= ctrl_next;
         result_reg <= result_next;
         refprog_reg <= refprog_next;
         legacy_reg <= legacy_next;
         irq_reg <= irq_next;
         busy_reg <= busy_next;
         start_pend_reg <= start_pend_next;
         presc_reg <= presc_next;
         mc_idx_reg <= mc_idx_next;
         trial_reg <= trial_next;
         mask_reg <= mask_next;
         final_reg <= final_next;
         sample_reg <= sample_next;
         state_reg <= state_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         lower_ext_reg <= lower_ext_next;
         upper_ext_reg <= upper_ext_next;
      end
   end

   // Outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign conversion_done_irq_flag = irq_reg;
   assign conversion_busy_flag = busy_reg;

   assign analog_ctrl.channel_sel = ctrl_reg[`ADCSQ_CTRL_MUX_MSB:`ADCSQ_CTRL_MUX_LSB];
   assign analog_ctrl.sample_en = sample_reg;
   assign analog_ctrl.sar_trial = trial_reg;
   assign analog_ctrl.lower_ref_code = refprog_reg[3:0];
   assign analog_ctrl.upper_ref_code = refprog_reg[7:4];
   // Registered external selects
   assign analog_ctrl.lower_ref_external = lower_ext_reg;
   assign analog_ctrl.upper_ref_external = upper_ext_reg;

endmodule

//--- dv/adcsq_ctrl_monitor.sv
module adcsq_ctrl_monitor (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Analog core and status
   input wire adcsq_pkg::adcsq_analog_t analog_ctrl,
   input wire adcsq_pkg::adcsq_compare_t analog_cmp,
   input wire logic [7:0] analog_digital_input_port,
   input wire logic conversion_done_irq_flag,
   input wire logic conversion_busy_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_done;
   assign wr_done = psel && penable && pready && pwrite && !pslverr;
   a_channel_follows: assert property (
      wr_done && paddr == 12'h360 |=> analog_ctrl.channel_sel == $past(pwdata[2:0]))
      else $error("channel select mismatch");
   a_ref_nibbles: assert property (
      wr_done && paddr == 12'h368 |=> analog_ctrl.lower_ref_code == $past(pwdata[3:0])
      && analog_ctrl.upper_ref_code == $past(pwdata[7:4]))
      else $error("reference codes mismatch");
   a_ref_external: assert property (
      analog_ctrl.lower_ref_external == (analog_ctrl.lower_ref_code == 4'h0)
      && analog_ctrl.upper_ref_external == (analog_ctrl.upper_ref_code == 4'h0))
      else $error("external reference select wrong");
   a_start_on_tick: assert property (
      wr_done && paddr == 12'h368 |-> ##[2:13] conversion_busy_flag && analog_ctrl.sample_en)
      else $error("conversion did not start");
   a_irq_sticky: assert property (
      conversion_done_irq_flag && !(wr_done && paddr == 12'h300) |=> conversion_done_irq_flag)
      else $error("done flag lost");
   a_busy_after_irq: assert property (
      $fell(conversion_busy_flag) |-> $past(conversion_done_irq_flag, 12))
      else $error("busy cleared without early done flag");
   a_trial_msb_first: assert property (
      $fell(analog_ctrl.sample_en) && conversion_busy_flag |-> analog_ctrl.sar_trial == 8'h80)
      else $error("first trial not msb");
   a_sample_busy: assert property (
      analog_ctrl.sample_en |-> conversion_busy_flag)
      else $error("sampling while not busy");
   c_done: cover property ($rose(conversion_done_irq_flag));
   c_abort: cover property (wr_done && paddr == 12'h368 && conversion_busy_flag);
   c_refused: cover property (pready && pslverr);
endmodule

bind adcsq_ctrl adcsq_ctrl_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .analog_ctrl(analog_ctrl), .analog_cmp(analog_cmp),
   .analog_digital_input_port(analog_digital_input_port),
   .conversion_done_irq_flag(conversion_done_irq_flag),
   .conversion_busy_flag(conversion_busy_flag));

//--- dv/adcsq_analog_model.sv
module adcsq_analog_model (
   // Clock
   input wire logic pclk,
   // Sequencer drive and comparator answers
   input wire adcsq_pkg::adcsq_analog_t analog_ctrl,
   output adcsq_pkg::adcsq_compare_t analog_cmp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic toggle_reg = 1'b0;
   logic [7:0] level;
   logic [8:0] up_lvl;
   logic [8:0] lo_lvl;
   always @(posedge pclk) toggle_reg <= ~toggle_reg;
   assign level = 8'h17 + 8'h1d * {5'h00, analog_ctrl.channel_sel};
   assign up_lvl = analog_ctrl.upper_ref_external ? 9'h100 :
                   {1'b0, analog_ctrl.upper_ref_code, 4'h0};
   assign lo_lvl = analog_ctrl.lower_ref_external ? 9'h000 :
                   {1'b0, analog_ctrl.lower_ref_code, 4'h0};
   always_comb begin
      analog_cmp.above_upper_ref = {1'b0, level} > up_lvl;
      analog_cmp.below_lower_ref = {1'b0, level} < lo_lvl;
      analog_cmp.cmp_above_trial = analog_ctrl.sample_en ? toggle_reg : level >= analog_ctrl.sar_trial;
   end
endmodule

//--- dv/adcsq_ctrl_test.sv
module adcsq_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] A_IRQ = 12'h300;
   localparam logic [11:0] A_CTRL = 12'h360;
   localparam logic [11:0] A_RES = 12'h364;
   localparam logic [11:0] A_REF = 12'h368;
   localparam logic [11:0] A_PORT = 12'h36c;
   localparam logic [11:0] A_CFG = 12'h370;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic busy;
   logic err;
   logic [31:0] q;
   logic [7:0] dig_port = 8'h5a;
   adcsq_pkg::adcsq_analog_t analog_ctrl;
   adcsq_pkg::adcsq_compare_t analog_cmp;
   int n_mismatch = 0;
   int check_count = 0;
   int n;

   initial forever #12.5 pclk = ~pclk;

   adcsq_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .analog_ctrl(analog_ctrl), .analog_cmp(analog_cmp),
      .analog_digital_input_port(dig_port), .conversion_done_irq_flag(irq),
      .conversion_busy_flag(busy));
   adcsq_analog_model i_model (.pclk(pclk), .analog_ctrl(analog_ctrl), .analog_cmp(analog_cmp));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(q, e);
   endtask
   task automatic wait_lvl(input logic lvl);
      n = 0;
      while (busy !== lvl && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (n == 400) begin
         n_mismatch++;
      end
   endtask
   function automatic logic [31:0] lvl(input int ch);
      return {24'h0, 8'h17 + 8'h1d * 8'(ch)};
   endfunction
   task automatic convert(input logic [7:0] refv, input logic [31:0] len, input logic [31:0] res);
      apb(1'b1, A_IRQ, 32'h0);
      apb(1'b1, A_REF, {24'h0, refv});
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      check(32'(n), len);
      check({31'h0, irq}, 32'h1);
      repeat (12) @(posedge pclk);
      rd(A_RES, res);
   endtask
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (10000) @(posedge pclk);
      n_mismatch++;
      finish_test();
   end

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_CTRL, 32'h0);
      rd(A_RES, 32'h0);
      rd(A_REF, 32'h0);
      rd(A_IRQ, 32'h0);
      apb(1'b0, 12'h3fc, 32'h0);
      check({31'h0, err}, 32'h1);
      apb(1'b1, A_RES, 32'h1a5);
      rd(A_RES, 32'ha5);
      apb(1'b1, A_CTRL, 32'h10);
      rd(A_CTRL, 32'h0);
      rd(A_PORT, 32'h5a);
      for (int ch = 0; ch < 8; ch++) begin
         apb(1'b1, A_CTRL, 32'(ch));
         convert(8'h00, 32'd132, lvl(ch));
      end
      repeat (30) @(posedge pclk);
      check({31'h0, busy}, 32'h0);
      apb(1'b1, A_CTRL, 32'h7);
      convert(8'h84, 32'd132, 32'hff);
      apb(1'b1, A_CTRL, 32'h0);
      convert(8'h84, 32'd132, 32'h00);
      apb(1'b1, A_CFG, 32'h1);
      rd(A_PORT, 32'h0);
      apb(1'b1, A_CTRL, 32'h3);
      convert(8'h00, 32'd156, lvl(3));
      apb(1'b1, A_CFG, 32'h0);
      apb(1'b1, A_CTRL, 32'hd);
      convert(8'h00, 32'd132, lvl(5));
      wait_lvl(1'b1);
      check(32'(n < 20), 32'h1);
      apb(1'b1, A_CTRL, 32'h5);
      wait_lvl(1'b0);
      repeat (40) @(posedge pclk);
      check({31'h0, busy}, 32'h0);
      apb(1'b1, A_REF, 32'h0);
      repeat (20) @(posedge pclk);
      apb(1'b1, A_CTRL, 32'h5);
      rd(A_CTRL, 32'h15);
      repeat (30) @(posedge pclk);
      apb(1'b1, A_REF, 32'h0);
      wait_lvl(1'b0);
      check(32'(n > 132 && n < 147), 32'h1);
      finish_test();
   end
endmodule
